/* core/xfer_cfg.svh */
`ifndef XFER_CFG_SVH
`define XFER_CFG_SVH
// register offsets on the local register port
`define OFS_FLAGS 8'h10
`define OFS_PORT01_MODE 8'h11
`define OFS_PORT2_MODE 8'h12
`define OFS_PORT3_MODE 8'h13
`define OFS_PRESCALER0 8'h14
`define OFS_PRESCALER1 8'h15
`define OFS_IRQ_PRIORITY 8'h16
`define OFS_CMD 8'h17
`define OFS_OPA 8'h18
`define OFS_OPB 8'h19
// flag bit positions
`define FLAG_C 7
`define FLAG_Z 6
`define FLAG_S 5
`define FLAG_V 4
// mode fields and the codes that enable them
`define PORT01_AD_LSB 3
`define PORT01_HI_LSB 0
`define PORT3_SEL_LSB 3
`define AD_ON 2'h2
`define HI_NIBBLE 2'h2
`define HI_BYTE 2'h3
`define SEL_ON 2'h1
// command byte layout
`define CMD_OP_MSB 3
`define CMD_STORE_BIT 7
// reset values
`define RST_BYTE 8'h00
// external strobe timing
`define CLK_PERIOD_NS 10
`define STROBE_NS 30
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* core/xfer_pkg.sv */
package xfer_pkg;
    // command codes
    typedef enum logic [3:0] {
        op_none = 4'h0,
        op_test_zero = 4'h1,
        op_test_one = 4'h2,
        op_and = 4'h3,
        op_or = 4'h4,
        op_xor = 4'h5,
        op_invert = 4'h6,
        op_load_prog = 4'h8,
        op_load_ext = 4'h9,
        op_load_prog_inc = 4'hA,
        op_load_ext_inc = 4'hB
    } op_t;
    // memory cycle sequencer, one-hot
    typedef enum logic [3:0] {
        st_idle = 4'h1,
        st_addr = 4'h2,
        st_strobe = 4'h4,
        st_done = 4'h8
    } fsm_t;
    // all state of the core
    typedef struct packed {
        logic [15:0][7:0] regs;
        logic [7:0] flags;
        logic [7:0] port01_mode_reg;
        logic [7:0] port2_mode_reg;
        logic [7:0] port3_mode_reg;
        logic [7:0] prescaler0_reg;
        logic [7:0] prescaler1_reg;
        logic [7:0] irq_priority_reg;
        logic [7:0] opa;
        logic [7:0] opb;
        logic err;
        fsm_t st;
        logic [2:0] cnt;
        logic is_ext;
        logic inc;
        logic store;
        logic [3:0] ridx;
        logic [3:0] pptr;
        logic [2:0] pidx;
        logic [7:0] data;
        logic [7:0] rdata;
        logic [7:0] p0_out;
        logic [7:0] p0_oe;
        logic [7:0] ad_out;
        logic ad_oe;
        logic as_n;
        logic ds_n;
        logic rw;
        logic sel_n;
        logic [7:0] ad_sync1;
        logic [7:0] ad_sync2;
    } core_state_t;
endpackage

/* core/bit_alu.sv */
`timescale 1ns/10ps
`default_nettype none
`include "xfer_cfg.svh"

module bit_alu
    import xfer_pkg::*;
(
    // operation and operands
    input wire op_t op,
    input wire logic [7:0] dst,
    input wire logic [7:0] mask,
    input wire logic [7:0] flags_in,
    // outcome
    output logic [7:0] result,
    output logic write_dst,
    output logic [7:0] flags_out,
    output logic valid
);
    // one byte through the masked logic; mask bit one selects the bit
    always_comb begin
        result = 8'h00;
        write_dst = 1'b1;
        valid = 1'b1;
        case (op)
            op_test_zero: begin
                result = dst & mask;
                write_dst = 1'b0;
            end
            op_test_one: begin
                result = ~dst & mask;
                write_dst = 1'b0;
            end
            op_and: result = dst & mask;
            op_or: result = dst | mask;
            op_xor: result = dst ^ mask;
            op_invert: result = ~dst;
            default: begin
                write_dst = 1'b0;
                valid = 1'b0;
            end
        endcase
        // carry untouched, overflow always cleared
        flags_out = flags_in;
        flags_out[`FLAG_Z] = (result == 8'h00);
        flags_out[`FLAG_S] = result[7];
        flags_out[`FLAG_V] = 1'b0;
    end
endmodule
`default_nettype wire

/* core/xfer_bit_unit.sv */
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "xfer_cfg.svh"

// What this block does
// - 16, 12, 8 or zero address lines
// - eight lines reach 256; select doubles space
// - mode codes enable twelve lines and select
// - incrementing loads bump pointer and address pair
// - bit ops refuse the write-only control registers
// - mask bit one selects destination bit
// - masked and clears unselected bits
// - masked or sets selected bits
// - masked xor inverts selected bits
// - invert flips all bits, no mask
// - zero test writes only the flags
// - zero test sets zero when selection clear
// - zero test sign from result top bit
// - one test uses same mask selection
// - both tests clear overflow, keep carry and low four bits
// - one test sets zero when selection all ones
module xfer_bit_unit
    import xfer_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    // upper address port
    output logic [7:0] port0_out,
    output logic [7:0] port0_oe,
    // multiplexed address/data port
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe,
    // memory strobes
    output logic addr_strobe_n,
    output logic data_strobe_n,
    output logic read_write,
    output logic data_memory_select_n
);
    core_state_t s;
    core_state_t n;

    logic ad_en;
    logic sel_en;
    logic [1:0] hi_mode;
    logic [4:0] lines;
    logic [7:0] hi_oe;
    logic [7:0] status;
    logic [7:0] dst_val;
    logic dst_ok;
    logic dst_wo;
    logic cmd_wr;
    logic issue;
    op_t cmd_op;
    logic is_bit;
    logic is_mem;
    logic is_ext;
    logic is_inc;
    logic [3:0] ridx;
    logic [15:0] mem_addr;
    logic [15:0] pair_val;
    logic [7:0] alu_res;
    logic alu_wr;
    logic [7:0] alu_flags;
    logic alu_valid;

    // port mode decode
    assign ad_en = (s.port01_mode_reg[`PORT01_AD_LSB +: 2] == `AD_ON);
    assign hi_mode = s.port01_mode_reg[`PORT01_HI_LSB +: 2];
    assign sel_en = (s.port3_mode_reg[`PORT3_SEL_LSB +: 2] == `SEL_ON);

    // address lines in use: the low byte once ad_en is set, then a nibble or a byte above it
    always_comb begin
        lines = 5'h00;
        hi_oe = 8'h00;
        if (ad_en) begin
            lines = 5'h08;
            if (hi_mode == `HI_NIBBLE) begin
                lines = 5'h0C;
                hi_oe = 8'h0F;
            end else if (hi_mode == `HI_BYTE) begin
                lines = 5'h10;
                hi_oe = 8'hFF;
            end
        end
    end

    assign status = {s.st != st_idle, s.err, sel_en, lines};

    // register space as seen by the port and by the bit ops
    function automatic logic [7:0] read_space(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a < `OFS_FLAGS) begin
            v = s.regs[a[3:0]];
        end else begin
            case (a)
                `OFS_FLAGS: v = s.flags;
                `OFS_CMD: v = status;
                `OFS_OPA: v = s.opa;
                `OFS_OPB: v = s.opb;
                default: v = 8'h00; // write-only and unmapped read zero
            endcase
        end
        return v;
    endfunction

    // command decode
    assign cmd_wr = bus_wr && (bus_addr == `OFS_CMD);
    assign issue = cmd_wr && (s.st == st_idle);
    assign cmd_op = op_t'(bus_wdata[`CMD_OP_MSB:0]);
    assign is_bit = (cmd_op inside {op_test_zero, op_test_one, op_and, op_or, op_xor, op_invert});
    assign is_mem = (cmd_op inside {op_load_prog, op_load_ext, op_load_prog_inc, op_load_ext_inc});
    assign is_ext = (cmd_op == op_load_ext) || (cmd_op == op_load_ext_inc);
    assign is_inc = (cmd_op == op_load_prog_inc) || (cmd_op == op_load_ext_inc);

    // bit op destination: working registers and flags only
    assign dst_val = read_space(s.opa);
    assign dst_wo = (s.opa >= `OFS_PORT01_MODE) && (s.opa <= `OFS_IRQ_PRIORITY);
    assign dst_ok = (s.opa <= `OFS_FLAGS);

    // memory operands: pair names the address, register direct or indirect
    assign ridx = is_inc ? s.regs[s.opa[3:0]][3:0] : s.opa[3:0];
    assign mem_addr = {s.regs[{s.opb[3:1], 1'b0}], s.regs[{s.opb[3:1], 1'b1}]};
    assign pair_val = {s.regs[{s.pidx, 1'b0}], s.regs[{s.pidx, 1'b1}]};

    bit_alu alu (
        .op(cmd_op),
        .dst(dst_val),
        .mask(s.opb),
        .flags_in(s.flags),
        .result(alu_res),
        .write_dst(alu_wr),
        .flags_out(alu_flags),
        .valid(alu_valid)
    );

    // next state: port writes first, the instruction engine after so it wins
    always_comb begin
        n = s;
        n.ad_sync1 = ad_in;
        n.ad_sync2 = s.ad_sync1;
        n.rdata = bus_rd ? read_space(bus_addr) : 8'h00;
        n.p0_oe = hi_oe;
        if (bus_wr) begin
            case (bus_addr)
                `OFS_FLAGS: n.flags = bus_wdata;
                `OFS_PORT01_MODE: n.port01_mode_reg = bus_wdata;
                `OFS_PORT2_MODE: n.port2_mode_reg = bus_wdata;
                `OFS_PORT3_MODE: n.port3_mode_reg = bus_wdata;
                `OFS_PRESCALER0: n.prescaler0_reg = bus_wdata;
                `OFS_PRESCALER1: n.prescaler1_reg = bus_wdata;
                `OFS_IRQ_PRIORITY: n.irq_priority_reg = bus_wdata;
                `OFS_OPA: n.opa = bus_wdata;
                `OFS_OPB: n.opb = bus_wdata;
                default: begin
                    if (bus_addr < `OFS_FLAGS) begin
                        n.regs[bus_addr[3:0]] = bus_wdata;
                    end
                end
            endcase
        end
        // a command while a memory cycle runs is dropped and flagged
        if (cmd_wr && s.st != st_idle) begin
            n.err = 1'b1;
        end
        case (s.st)
            st_idle: begin
                if (issue) begin
                    if (is_bit && dst_ok && alu_valid) begin
                        n.err = 1'b0;
                        n.flags = alu_flags;
                        // a result aimed at the flags overrides the flag update
                        if (alu_wr) begin
                            if (s.opa == `OFS_FLAGS) begin
                                n.flags = alu_res;
                            end else begin
                                n.regs[s.opa[3:0]] = alu_res;
                            end
                        end
                    end else if (is_mem && ad_en) begin
                        n.err = 1'b0;
                        n.st = st_addr;
                        n.as_n = 1'b0;
                        n.ad_oe = 1'b1;
                        n.ad_out = mem_addr[7:0];
                        n.p0_out = mem_addr[15:8];
                        n.store = bus_wdata[`CMD_STORE_BIT];
                        n.rw = ~bus_wdata[`CMD_STORE_BIT];
                        n.sel_n = ~(is_ext && sel_en);
                        n.is_ext = is_ext;
                        n.inc = is_inc;
                        n.ridx = ridx;
                        n.pptr = s.opa[3:0];
                        n.pidx = s.opb[3:1];
                        n.data = s.regs[ridx];
                    end else begin
                        n.err = 1'b1;
                    end
                end
            end
            st_addr: begin
                // address latched by memory on the rising edge of the strobe
                n.as_n = 1'b1;
                n.ds_n = 1'b0;
                n.ad_oe = s.store;
                n.ad_out = s.store ? s.data : 8'h00;
                n.cnt = 3'(`STROBE_CYC - 1);
                n.st = st_strobe;
            end
            st_strobe: begin
                if (s.cnt == 3'h0) begin
                    n.ds_n = 1'b1;
                    n.st = st_done;
                end else begin
                    n.cnt = s.cnt - 3'h1;
                end
            end
            st_done: begin
                // read data taken from the synchroniser output, two edges late
                if (!s.store) begin
                    n.regs[s.ridx] = s.ad_sync2;
                end
                if (s.inc) begin
                    n.regs[s.pptr] = s.regs[s.pptr] + 8'h01;
                    {n.regs[{s.pidx, 1'b0}], n.regs[{s.pidx, 1'b1}]} = pair_val + 16'h0001;
                end
                n.ad_oe = 1'b0;
                n.rw = 1'b1;
                n.sel_n = 1'b1;
                n.st = st_idle;
            end
            default: n.st = st_idle;
        endcase
    end

    // state register; reset loads constants only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.flags <= `RST_BYTE;
            s.port01_mode_reg <= `RST_BYTE;
            s.port3_mode_reg <= `RST_BYTE;
            s.st <= st_idle;
            s.as_n <= 1'b1;
            s.ds_n <= 1'b1;
            s.rw <= 1'b1;
            s.sel_n <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // every output straight from the state register
    assign bus_rdata = s.rdata;
    assign port0_out = s.p0_out;
    assign port0_oe = s.p0_oe;
    assign ad_out = s.ad_out;
    assign ad_oe = s.ad_oe;
    assign addr_strobe_n = s.as_n;
    assign data_strobe_n = s.ds_n;
    assign read_write = s.rw;
    assign data_memory_select_n = s.sel_n;

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    property p_zero_test_z;
        (issue && cmd_op == op_test_zero && dst_ok)
            |=> s.flags[`FLAG_Z] == $past((dst_val & s.opb) == 8'h00);
    endproperty
    a_zero_test_z: assert property (p_zero_test_z)
        else $error("zero test gave wrong zero flag");
    property p_zero_test_s;
        (issue && cmd_op == op_test_zero && dst_ok)
            |=> s.flags[`FLAG_S] == $past(dst_val[7] & s.opb[7]);
    endproperty
    a_zero_test_s: assert property (p_zero_test_s)
        else $error("zero test gave wrong sign flag");
    property p_one_test_z;
        (issue && cmd_op == op_test_one && dst_ok)
            |=> s.flags[`FLAG_Z] == $past((dst_val & s.opb) == s.opb);
    endproperty
    a_one_test_z: assert property (p_one_test_z)
        else $error("one test gave wrong zero flag");
    property p_test_flags;
        (issue && (cmd_op == op_test_zero || cmd_op == op_test_one) && dst_ok)
            |=> !s.flags[`FLAG_V] && s.flags[`FLAG_C] == $past(s.flags[`FLAG_C]);
    endproperty
    a_test_flags: assert property (p_test_flags)
        else $error("test touched overflow or carry wrongly");
    property p_test_keep;
        (issue && (cmd_op == op_test_zero || cmd_op == op_test_one))
            |=> s.regs == $past(s.regs) && s.opb == $past(s.opb);
    endproperty
    a_test_keep: assert property (p_test_keep)
        else $error("test modified an operand");
    property p_and;
        (issue && cmd_op == op_and && s.opa < `OFS_FLAGS)
            |=> s.regs[$past(s.opa[3:0])] == $past(dst_val & s.opb);
    endproperty
    a_and: assert property (p_and)
        else $error("masked and result wrong");
    property p_or;
        (issue && cmd_op == op_or && s.opa < `OFS_FLAGS)
            |=> s.regs[$past(s.opa[3:0])] == $past(dst_val | s.opb);
    endproperty
    a_or: assert property (p_or)
        else $error("masked or result wrong");
    property p_xor;
        (issue && cmd_op == op_xor && s.opa < `OFS_FLAGS)
            |=> s.regs[$past(s.opa[3:0])] == $past(dst_val ^ s.opb);
    endproperty
    a_xor: assert property (p_xor)
        else $error("masked xor result wrong");
    property p_invert;
        (issue && cmd_op == op_invert && s.opa < `OFS_FLAGS)
            |=> s.regs[$past(s.opa[3:0])] == ~$past(dst_val);
    endproperty
    a_invert: assert property (p_invert)
        else $error("invert result wrong");
    property p_write_only;
        (issue && is_bit && dst_wo)
            |=> s.err && s.regs == $past(s.regs) && s.flags == $past(s.flags);
    endproperty
    a_write_only: assert property (p_write_only)
        else $error("bit op on write-only register not refused");
    // level taken at the issue edge, then held for the rest of the cycle
    property p_select;
        (issue && is_mem && ad_en)
            |=> data_memory_select_n == $past(!(is_ext && sel_en)) ##1 $stable(data_memory_select_n) [*4];
    endproperty
    a_select: assert property (p_select)
        else $error("data memory select wrong during cycle");
    property p_pair_inc;
        (s.st == st_done && s.inc && s.pptr[3:1] != s.pidx && s.ridx[3:1] != s.pidx)
            |=> pair_val == $past(pair_val) + 16'h0001;
    endproperty
    a_pair_inc: assert property (p_pair_inc)
        else $error("address pair not incremented");
    property p_twelve;
        (bus_wr && bus_addr == `OFS_PORT01_MODE && bus_wdata == 8'h12)
            |=> lines == 5'h0C ##1 port0_oe == 8'h0F;
    endproperty
    a_twelve: assert property (p_twelve)
        else $error("mode code did not give twelve lines");
    property p_strobe;
        (s.st == st_addr) |=> !data_strobe_n [*3] ##1 data_strobe_n;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("data strobe width wrong");
endmodule
`default_nettype wire

/* verif/ext_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none

// external program and data memory on the multiplexed port bus
module ext_mem_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bus from the core
    input wire logic [7:0] port0_out,
    input wire logic [7:0] port0_oe,
    input wire logic [7:0] ad_out,
    input wire logic addr_strobe_n,
    input wire logic data_strobe_n,
    input wire logic read_write,
    input wire logic data_memory_select_n,
    // read data back to the core
    output logic [7:0] ad_in
);
    // select bit splits the space in two halves, undriven lines count as zero
    logic [7:0] mem [0:131071];
    logic [16:0] cur;
    wire [16:0] idx = {data_memory_select_n, port0_out & port0_oe, ad_out};

    // latch address at the strobe, hold read byte through the data strobe
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            ad_in <= 8'h00;
        end else if (!addr_strobe_n) begin
            cur <= idx;
            ad_in <= read_write ? mem[idx] : ~ad_in;
        end else if (!data_strobe_n && !read_write) begin
            mem[cur] <= ad_out;
        end else if (data_strobe_n) begin
            ad_in <= ~ad_in; // released bus inverts the held byte on every clock
        end
    end
endmodule

`default_nettype wire

/* verif/xfer_bit_unit_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "xfer_cfg.svh"

module xfer_bit_unit_tb
    import xfer_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    logic [7:0] port0_out;
    logic [7:0] port0_oe;
    logic [7:0] ad_in;
    logic [7:0] ad_out;
    logic ad_oe;
    logic addr_strobe_n;
    logic data_strobe_n;
    logic read_write;
    logic data_memory_select_n;
    integer errors = 0;
    integer n_checks = 0;
    integer cycles = 0;
    integer i;
    integer j;
    logic [7:0] r;
    op_t ops [6] = '{op_test_zero, op_test_one, op_and, op_or, op_xor, op_invert};
    logic [7:0] dv [5] = '{8'h8C, 8'h7C, 8'h8C, 8'hFC, 8'h18};
    logic [7:0] mv [5] = '{8'h70, 8'h70, 8'hF0, 8'hF0, 8'hA1};
    logic [7:0] pm [4] = '{8'h00, 8'h10, 8'h12, 8'h13};
    logic [4:0] ln [4] = '{5'h00, 5'h08, 5'h0C, 5'h10};

    always #5 sys_clk = ~sys_clk;

    xfer_bit_unit DUT (
        .sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .port0_out(port0_out),
        .port0_oe(port0_oe), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
        .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n),
        .read_write(read_write), .data_memory_select_n(data_memory_select_n)
    );

    ext_mem_model mem_model (
        .sys_clk(sys_clk), .rst(rst), .port0_out(port0_out), .port0_oe(port0_oe),
        .ad_out(ad_out), .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n),
        .read_write(read_write), .data_memory_select_n(data_memory_select_n), .ad_in(ad_in)
    );

    task automatic final_report;
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    // read data only stands in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        @(negedge sys_clk);
        chk(bus_rdata, exp);
    endtask

    // issue a memory command and watch the address and strobe phases
    task automatic mem_op(input logic [7:0] cmd, input logic [15:0] a, input logic sel_n);
        wr(`OFS_CMD, cmd);
        @(negedge sys_clk);
        chk(ad_out, a[7:0]);
        chk(port0_oe, 8'h0F);
        chk({4'h0, port0_out[3:0]}, {4'h0, a[11:8]});
        chk({6'h00, data_memory_select_n, read_write}, {6'h00, sel_n, ~cmd[7]});
        chk({6'h00, ad_oe, addr_strobe_n}, 8'h02);
        @(negedge sys_clk);
        // bus driven in the strobe phase only for a store
        chk({6'h00, ad_oe, data_strobe_n}, {6'h00, cmd[7], 1'b0});
        repeat (3) @(negedge sys_clk);
        chk({7'h00, data_strobe_n}, 8'h01);
        @(negedge sys_clk);
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            final_report;
        end
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk(`OFS_FLAGS, 8'h00);
        // no address lines yet, so a memory command is refused
        wr(`OFS_CMD, {4'h0, op_load_ext});
        rdchk(`OFS_CMD, 8'h40);
        for (i = 0; i < 4; i++) begin
            wr(`OFS_PORT01_MODE, pm[i]);
            rdchk(`OFS_CMD, {3'b010, ln[i]});
        end
        wr(`OFS_PORT01_MODE, 8'h12);
        wr(`OFS_PORT3_MODE, 8'h08);
        rdchk(`OFS_CMD, 8'h6C);
        // every bit op over a table of operands, flags preset to F5
        wr(`OFS_OPA, 8'h03);
        for (i = 0; i < 6; i++) begin
            for (j = 0; j < 5; j++) begin
                wr(8'h03, dv[j]);
                wr(`OFS_OPB, mv[j]);
                wr(`OFS_FLAGS, 8'hF5);
                wr(`OFS_CMD, {4'h0, ops[i]});
                case (ops[i])
                    op_test_one: r = ~dv[j] & mv[j];
                    op_or: r = dv[j] | mv[j];
                    op_xor: r = dv[j] ^ mv[j];
                    op_invert: r = ~dv[j];
                    default: r = dv[j] & mv[j];
                endcase
                rdchk(8'h03, (ops[i] == op_test_zero || ops[i] == op_test_one) ? dv[j] : r);
                rdchk(`OFS_FLAGS, {1'b1, r == 8'h00, r[7], 1'b0, 4'h5});
            end
        end
        // flags as destination: the result replaces the flag update
        wr(`OFS_OPA, `OFS_FLAGS);
        wr(`OFS_OPB, 8'h0F);
        wr(`OFS_FLAGS, 8'hF5);
        wr(`OFS_CMD, {4'h0, op_xor});
        rdchk(`OFS_FLAGS, 8'hFA);
        rdchk(`OFS_CMD, 8'h2C);
        // write-only registers refused; a hit on the mode register would change the line count
        wr(`OFS_OPB, 8'hFF);
        for (i = 8'h11; i <= 8'h16; i++) begin
            wr(`OFS_OPA, i[7:0]);
            wr(`OFS_CMD, {4'h0, op_or});
            rdchk(`OFS_CMD, 8'h6C);
        end
        // same address in both spaces holds different bytes
        wr(8'h04, 8'h0A);
        wr(8'h05, 8'h37);
        wr(`OFS_OPB, 8'h04);
        wr(`OFS_OPA, 8'h01);
        mem_model.mem[{1'b0, 16'h0A37}] = 8'hC3;
        mem_model.mem[{1'b1, 16'h0A37}] = 8'h3C;
        mem_op({4'h0, op_load_ext}, 16'h0A37, 1'b0);
        rdchk(8'h01, 8'hC3);
        rdchk(`OFS_CMD, 8'h2C);
        wr(`OFS_OPA, 8'h02);
        mem_op({4'h0, op_load_prog}, 16'h0A37, 1'b1);
        rdchk(8'h02, 8'h3C);
        // incrementing store with a carry out of the low address byte
        wr(8'h06, 8'h08);
        wr(8'h08, 8'h5A);
        wr(8'h0A, 8'h01);
        wr(8'h0B, 8'hFF);
        wr(`OFS_OPA, 8'h06);
        wr(`OFS_OPB, 8'h0A);
        mem_op({4'h8, op_load_ext_inc}, 16'h01FF, 1'b0);
        chk(mem_model.mem[{1'b0, 16'h01FF}], 8'h5A);
        rdchk(8'h06, 8'h09);
        rdchk(8'h0A, 8'h02);
        rdchk(8'h0B, 8'h00);
        // incrementing program read follows the bumped pointers
        mem_model.mem[{1'b1, 16'h0200}] = 8'h96;
        mem_op({4'h0, op_load_prog_inc}, 16'h0200, 1'b1);
        rdchk(8'h09, 8'h96);
        rdchk(8'h06, 8'h0A);
        rdchk(8'h0B, 8'h01);
        final_report;
    end
endmodule

`default_nettype wire
